//--- test/adq_ctrl_tb_top.sv
/* testbench: drives the core end, checks registers, scans, triggers and requests.
   assumes: both ends joined by adq_if, 100 MHz clock. */
`timescale 1ns/1ps
module adq_ctrl_tb_top;
  import adq_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] u_addr = 8'h00, u_wdata = 8'h00, u_conv_data = 8'h00;
  logic u_wr = 1'b0, u_pin_low = 1'b0, u_timer_pulse = 1'b0, u_pin_alt = 1'b1;
  logic [7:0] lo6 = 8'h00, lo7 = 8'h00, up6 = 8'hFF, up7 = 8'hFF;
  logic [7:0] u_rdata, u_vector;
  logic u_irq, u_bias_ready;
  int err_total = 0, checked = 0, n_strobe = 0;
  logic [7:0] fl[6] = '{8'hF0, 8'hA0, 8'h50, 8'hC0, 8'h00, 8'hB0};
  logic [7:0] tc[5] = '{8'h94, 8'hAC, 8'h04, 8'h1C, 8'h01};
  logic [1:0] tk[5] = '{2'b10, 2'b01, 2'b11, 2'b01, 2'b00};
  int tn[5] = '{4, 3, 0, 8, 0};
  always #5 mclk = ~mclk;
  adq_if ifc (.mclk(mclk));
  adq_ctrl i_adq_ctrl (.mclk(mclk), .rst_n(rst_n), .bus(ifc.dev), .low_thr6(lo6),
    .low_thr7(lo7), .up_thr6(up6), .up_thr7(up7));
  adq_core i_adq_core (.mclk(mclk), .rst_n(rst_n), .bus(ifc.core), .u_addr(u_addr),
    .u_wdata(u_wdata), .u_wr(u_wr), .u_pin_low(u_pin_low), .u_timer_pulse(u_timer_pulse),
    .u_pin_alt(u_pin_alt),
    .u_conv_data(u_conv_data), .u_rdata(u_rdata), .u_irq(u_irq), .u_vector(u_vector),
    .u_bias_ready(u_bias_ready));
  adq_properties i_adq_properties (.mclk(mclk), .rst_n(rst_n), .reg_addr(ifc.reg_addr),
    .reg_wdata(ifc.reg_wdata), .reg_wr(ifc.reg_wr), .conv_strobe(ifc.conv_strobe),
    .conv_channel(ifc.conv_channel), .analog_bias_on(ifc.analog_bias_on),
    .irq_req(ifc.irq_req), .irq_priority_level(ifc.irq_priority_level),
    .irq_vector(ifc.irq_vector));
  always @(posedge mclk) if (ifc.conv_strobe === 1'b1) n_strobe++;
  function automatic logic exp_irq(logic [7:0] d);
    return (d[7] & d[5]) | (d[6] & d[4]);
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    u_addr <= a;
    u_wdata <= d;
    u_wr <= 1'b1;
    @(posedge mclk);
    u_wr <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] m,
      input logic [7:0] e);
    @(posedge mclk);
    u_addr <= a;
    repeat (4) @(posedge mclk);
    #1 chk(n, e & m, u_rdata & m);
  endtask
  task automatic seq(input logic [7:0] ic, input logic [7:0] c, input logic [1:0] k,
      input int n, input logic [7:0] dv);
    u_conv_data <= dv;
    wr(ADQ_OFS_IRQ_CONTROL, ic);
    wr(ADQ_OFS_CONTROL, c);
    n_strobe = 0;
    u_pin_low <= k[1];
    u_timer_pulse <= k[0];
    @(posedge mclk);
    u_timer_pulse <= 1'b0;
    repeat (2) @(posedge mclk);
    u_pin_low <= 1'b0;
    repeat (n * (int'(ADQ_CONV_CYCLES) + 1) + 8) @(posedge mclk);
    repeat (4) @(posedge mclk);
    chk("strobes", 8'(n), 8'(n_strobe));
    rdchk("eoc", ADQ_OFS_IRQ_CONTROL, 8'h80, (n > 0) ? 8'h80 : 8'h00);
    if (n > 0) rdchk("run", ADQ_OFS_CONTROL, 8'h01, 8'h00);
  endtask
  task automatic power_up();
    wr(ADQ_OFS_CONTROL, 8'h04);
    repeat (ADQ_BIAS_CYCLES / 2) @(posedge mclk);
    #1 chk("bias early", 8'h00, {7'h00, u_bias_ready});
    for (int i = 0; i < ADQ_BIAS_CYCLES && u_bias_ready !== 1'b1; i++) @(posedge mclk);
    #1 chk("bias", 8'h01, {7'h00, u_bias_ready});
  endtask
  task automatic conclude();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    conclude();
  end
  initial begin
    logic [7:0] d;
    d = 8'($urandom(25443));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk("ctrl", ADQ_OFS_CONTROL, 8'hFF, ADQ_RST_CONTROL);
    rdchk("icr", ADQ_OFS_IRQ_CONTROL, 8'hFF, ADQ_RST_IRQ_CONTROL);
    rdchk("ivr", ADQ_OFS_IRQ_VECTOR, 8'hFF, ADQ_RST_IRQ_VECTOR);
    wr(ADQ_OFS_LIMIT_RESULT, 8'h00);
    wr(8'h10, 8'hFF);
    rdchk("crr", ADQ_OFS_LIMIT_RESULT, 8'hFF, ADQ_RST_LIMIT_RESULT);
    rdchk("ctrl", ADQ_OFS_CONTROL, 8'hFF, ADQ_RST_CONTROL);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(ADQ_OFS_IRQ_VECTOR, d);
      rdchk("vec", ADQ_OFS_IRQ_VECTOR, 8'hFD, d & 8'hFC);
      wr(ADQ_OFS_IRQ_CONTROL, 8'(i));
      rdchk("prio", ADQ_OFS_IRQ_CONTROL, 8'h07, 8'(i));
    end
    foreach (fl[i]) begin
      wr(ADQ_OFS_IRQ_CONTROL, fl[i]);
      repeat (5) @(posedge mclk);
      #1 chk("irq", {7'h00, exp_irq(fl[i])}, {7'h00, u_irq});
      if (exp_irq(fl[i])) chk("wsel", {7'h00, !(fl[i][6] & fl[i][4])}, {7'h00, u_vector[1]});
    end
    power_up();
    for (int f = 0; f < 8; f++) begin
      seq(8'h20, {3'(f), 5'h05}, 2'b00, 8 - f, 8'($urandom) & 8'h7F);
    end
    foreach (tc[i]) begin
      seq(8'h20, tc[i], tk[i], tn[i], 8'($urandom) & 8'h7F);
    end
    power_up();
    u_pin_alt <= 1'b0;
    seq(8'h20, 8'h94, 2'b10, 0, 8'($urandom) & 8'h7F);
    u_pin_alt <= 1'b1;
    lo6 <= 8'h20;
    up7 <= 8'h10;
    seq(8'h30, 8'hC5, 2'b00, 2, 8'h10);
    rdchk("crr", ADQ_OFS_LIMIT_RESULT, 8'hFF, 8'h9F);
    chk("wsel", 8'h00, {7'h00, u_vector[1]});
    wr(ADQ_OFS_IRQ_CONTROL, 8'h30);
    rdchk("crr", ADQ_OFS_LIMIT_RESULT, 8'hFF, ADQ_RST_LIMIT_RESULT);
    lo6 <= 8'h00;
    up7 <= 8'hFF;
    wr(ADQ_OFS_CONTROL, 8'hC7);
    n_strobe = 0;
    repeat (100) @(posedge mclk);
    chk("repeat", 8'h01, {7'h00, n_strobe >= 5});
    wr(ADQ_OFS_CONTROL, 8'hC4);
    repeat (3) @(posedge mclk);
    n_strobe = 0;
    repeat (60) @(posedge mclk);
    chk("stop", 8'h00, 8'(n_strobe));
    conclude();
  end
endmodule

//--- test/adq_properties.sv
/* checker: timing relations between the two ends of the converter link.
   assumes: one clock, rst_n synchronous active low, no write while idle checks run. */
`timescale 1ns/1ps
module adq_properties
  import adq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic conv_strobe,
  input wire logic [2:0] conv_channel,
  input wire logic analog_bias_on,
  input wire logic irq_req,
  input wire logic [2:0] irq_priority_level,
  input wire logic [7:0] irq_vector
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic seen_r;
  logic wr_d_r;
  logic [2:0] last_r;
  wire ctl_wr = reg_wr && reg_addr == ADQ_OFS_CONTROL;
  wire icr_wr = reg_wr && reg_addr == ADQ_OFS_IRQ_CONTROL;
  // remember the channel of the previous strobe within one sequence
  always_ff @(posedge mclk) begin
    wr_d_r <= ctl_wr;
    if (!rst_n || ctl_wr || wr_d_r) seen_r <= 1'b0;
    else if (conv_strobe) seen_r <= 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (conv_strobe) last_r <= conv_channel;
  end
  sequence s_quiet3;
    !reg_wr [*3];
  endsequence
  property p_start;
    logic [2:0] f;
    (ctl_wr && reg_wdata[2] && reg_wdata[0], f = reg_wdata[7:5]) ##1 !reg_wr
      |-> ##[0:2] (conv_strobe && conv_channel == f);
  endproperty
  property p_wsel;
    logic w;
    (icr_wr && reg_wdata[5:4] == 2'b11 && reg_wdata[7:6] != 2'b00, w = reg_wdata[6])
      ##1 s_quiet3 |-> irq_vector[1] == !w;
  endproperty
  property p_prio;
    logic [2:0] p;
    (icr_wr, p = reg_wdata[2:0]) ##1 !reg_wr |=> irq_priority_level == p;
  endproperty
  property p_base;
    logic [5:0] v;
    (reg_wr && reg_addr == ADQ_OFS_IRQ_VECTOR, v = reg_wdata[7:2]) ##1 !reg_wr
      |=> irq_vector[7:2] == v;
  endproperty
  a_vec_bit_zero: assert property (irq_vector[0] == 1'b0)
    else $error("vector bit 0 not zero");
  a_scan_step: assert property (conv_strobe && seen_r && last_r != 3'h7 |-> conv_channel == last_r + 3'h1)
    else $error("channel did not step by one");
  a_start_first: assert property (p_start)
    else $error("run write did not start at first channel");
  a_stop_quiet: assert property ((ctl_wr && reg_wdata[4:3] == 2'b00 && !reg_wdata[0]) |=> !conv_strobe [*2])
    else $error("strobe after stop");
  a_power_gate: assert property (conv_strobe |-> analog_bias_on)
    else $error("strobe while powered down");
  a_irq_masked: assert property ((icr_wr && reg_wdata[5:4] == 2'b00) ##1 !reg_wr |=> !irq_req)
    else $error("request with both enables clear");
  a_sw_irq: assert property ((icr_wr && ((reg_wdata[7] && reg_wdata[5]) || (reg_wdata[6] && reg_wdata[4]))) ##1 !reg_wr |=> irq_req)
    else $error("software flag raised no request");
  a_word_sel: assert property (p_wsel)
    else $error("word select names wrong source");
  a_prio_level: assert property (p_prio)
    else $error("priority output differs");
  a_vec_base: assert property (p_base)
    else $error("vector base differs");
endmodule

//--- verilog/adq_core.sv
/*
  core-side end: drives register writes, trigger sources and converter data
  from a plain user port; reports interrupt and read data back.
  assumes: the user keeps trigger spacing and power-up lead time.
*/
`timescale 1ns/1ps
module adq_core
  import adq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link
  adq_if.core bus,
  // user requests
  input wire logic [7:0] u_addr,
  input wire logic [7:0] u_wdata,
  input wire logic u_wr,
  input wire logic u_pin_low,
  input wire logic u_pin_alt,
  input wire logic u_timer_pulse,
  input wire logic [7:0] u_conv_data,
  // user results
  output logic [7:0] u_rdata,
  output logic u_irq,
  output logic [7:0] u_vector,
  output logic u_bias_ready
);
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic wr_r;
  logic pin_r;
  logic alt_r;
  logic timer_r;
  logic [7:0] conv_r;
  logic [31:0] bias_cnt_r;
  logic [7:0] rdata_r;
  logic irq_r;
  logic [7:0] vec_r;
  logic bias_ready_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      pin_r <= 1'b1;
      alt_r <= 1'b1;
      timer_r <= 1'b0;
      conv_r <= 8'h00;
    end else begin
      addr_r <= u_addr;
      wdata_r <= u_wdata;
      wr_r <= u_wr;
      pin_r <= !u_pin_low;
      alt_r <= u_pin_alt;
      timer_r <= u_timer_pulse;
      conv_r <= u_conv_data;
    end
  end

  // bias lead-time counter after power bit set
  always_ff @(posedge mclk) begin
    if (!rst_n || !bus.analog_bias_on) begin
      bias_cnt_r <= 32'h0000_0000;
      bias_ready_r <= 1'b0;
    end else if (bias_cnt_r == 32'(ADQ_BIAS_CYCLES)) begin
      bias_ready_r <= 1'b1;
    end else begin
      bias_cnt_r <= bias_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      vec_r <= 8'h00;
    end else begin
      rdata_r <= bus.reg_rdata;
      irq_r <= bus.irq_req;
      vec_r <= bus.irq_vector;
    end
  end

  assign bus.reg_addr = addr_r;
  assign bus.reg_wdata = wdata_r;
  assign bus.reg_wr = wr_r;
  assign bus.trigger_pin = pin_r;
  assign bus.trigger_pin_alt = alt_r;
  assign bus.timer_event = timer_r;
  assign bus.conv_data = conv_r;
  assign bus.irq_ack = 1'b0;
  assign u_rdata = rdata_r;
  assign u_irq = irq_r;
  assign u_vector = vec_r;
  assign u_bias_ready = bias_ready_r;
endmodule

//--- verilog/adq_ctrl.sv
/*
  converter sequencer and interrupt control: control, interrupt control,
  vector and limit result registers, autoscan sequencing, triggers, watchdog.
  assumes: the analog converter returns conv_data ADQ_CONV_CYCLES after a
  channel starts; register writes and reads are single-cycle.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - control write aborts and restarts sequencing
// - scan from first channel up to seven
// - pin edge starts sequence when enabled
// - timer event starts sequence when enabled
// - both trigger sources are ORed
// - trigger sets run; single mode clears it
// - triggers pulse low long, spaced beyond sequence
// - power bit gates all converter activity
// - single mode runs one sequence per start
// - repeat mode keeps sequencing after first start
// - run bit write starts or stops
// - end flag set when group completes
// - software flag write raises request
// - watchdog flag on channel six/seven out-of-range
// - enable bits mask each request
// - priority level field drives output
// - software programs vector base bits
// - word select names the serving source
// - watchdog served first, end held pending
// - vector bit zero reads zero
// - compare bits clear with watchdog flag clear
// - power set 60 us before start
module adq_ctrl
  import adq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link to core
  adq_if.dev bus,
  // threshold values
  input wire logic [7:0] low_thr6,
  input wire logic [7:0] low_thr7,
  input wire logic [7:0] up_thr6,
  input wire logic [7:0] up_thr7
);
  logic [7:0] control_r;
  logic [7:0] irq_control_r;
  logic [7:0] irq_vector_r;
  logic [7:0] limit_result_reg_r;
  logic [7:0] rdata_r;
  adq_state_type state_r;
  logic [2:0] channel_r;
  logic [7:0] conv_cnt_r;
  logic pin_d_r;
  logic strobe_r;
  logic irq_r;
  logic ctrl_wr;
  logic icr_wr;
  logic trig;
  logic seq_done;
  logic [3:0] cmp_hit;
  logic [3:0] hit_now;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  assign ctrl_wr = bus.reg_wr && addr_is(bus.reg_addr, ADQ_OFS_CONTROL);
  assign icr_wr = bus.reg_wr && addr_is(bus.reg_addr, ADQ_OFS_IRQ_CONTROL);
  // falling edge on the alternate-function pin, or the timer event
  assign trig = control_r[ADQ_POWER_BIT] &&
    ((control_r[ADQ_PIN_TRIG_BIT] && bus.trigger_pin_alt && pin_d_r && !bus.trigger_pin) ||
     (control_r[ADQ_TIMER_TRIG_BIT] && bus.timer_event));
  assign seq_done = (state_r == ADQ_NEXT) && (channel_r == ADQ_LAST_CHANNEL);
  // compare hits: {7 upper, 6 upper, 7 lower, 6 lower}
  assign cmp_hit[3] = (channel_r == ADQ_LAST_CHANNEL) && (bus.conv_data >= up_thr7);
  assign cmp_hit[2] = (channel_r == ADQ_WATCH_CH_A) && (bus.conv_data >= up_thr6);
  assign cmp_hit[1] = (channel_r == ADQ_LAST_CHANNEL) && (bus.conv_data < low_thr7);
  assign cmp_hit[0] = (channel_r == ADQ_WATCH_CH_A) && (bus.conv_data < low_thr6);
  assign hit_now = cmp_hit & {4{state_r == ADQ_NEXT}};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_d_r <= 1'b1;
    end else begin
      pin_d_r <= bus.trigger_pin;
    end
  end

  // control register and run bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      control_r <= ADQ_RST_CONTROL;
    end else if (ctrl_wr) begin
      control_r <= bus.reg_wdata;
    end else if (trig) begin
      control_r[ADQ_RUN_BIT] <= 1'b1;
    end else if (seq_done && !control_r[ADQ_REPEAT_BIT]) begin
      control_r[ADQ_RUN_BIT] <= 1'b0;
    end
  end

  // autoscan sequencer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= ADQ_IDLE;
      channel_r <= 3'h0;
      conv_cnt_r <= 8'h00;
      strobe_r <= 1'b0;
    end else if (ctrl_wr || !control_r[ADQ_POWER_BIT]) begin
      state_r <= ADQ_IDLE;
      channel_r <= ctrl_wr ? bus.reg_wdata[ADQ_FIRST_HI:ADQ_FIRST_LO] :
        control_r[ADQ_FIRST_HI:ADQ_FIRST_LO];
      conv_cnt_r <= 8'h00;
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= 1'b0;
      case (state_r)
        ADQ_IDLE: begin
          channel_r <= control_r[ADQ_FIRST_HI:ADQ_FIRST_LO];
          if (control_r[ADQ_RUN_BIT]) begin
            state_r <= ADQ_CONV;
            conv_cnt_r <= ADQ_CONV_CYCLES;
            strobe_r <= 1'b1;
          end
        end
        ADQ_CONV: begin
          if (conv_cnt_r == 8'h01) begin
            state_r <= ADQ_NEXT;
          end
          conv_cnt_r <= conv_cnt_r - 8'h01;
        end
        ADQ_NEXT: begin
          if (channel_r == ADQ_LAST_CHANNEL) begin
            state_r <= ADQ_IDLE;
          end else begin
            channel_r <= channel_r + 3'h1;
            state_r <= ADQ_CONV;
            conv_cnt_r <= ADQ_CONV_CYCLES;
            strobe_r <= 1'b1;
          end
        end
        default: begin
          state_r <= ADQ_IDLE;
        end
      endcase
    end
  end

  // interrupt control: hardware set wins over software clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_control_r <= ADQ_RST_IRQ_CONTROL;
    end else begin
      if (icr_wr) begin
        irq_control_r <= bus.reg_wdata;
      end
      if (seq_done) begin
        irq_control_r[ADQ_EOC_FLAG_BIT] <= 1'b1;
      end
      if (|hit_now) begin
        irq_control_r[ADQ_LIM_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // limit result bits, low nibble reads as ones
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      limit_result_reg_r <= ADQ_RST_LIMIT_RESULT;
    end else if (icr_wr && !bus.reg_wdata[ADQ_LIM_FLAG_BIT]) begin
      limit_result_reg_r <= ADQ_RST_LIMIT_RESULT | {hit_now, 4'h0};
    end else begin
      limit_result_reg_r[7:4] <= limit_result_reg_r[7:4] | hit_now;
    end
  end

  // vector register and source word select
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_vector_r <= ADQ_RST_IRQ_VECTOR;
    end else begin
      if (bus.reg_wr && addr_is(bus.reg_addr, ADQ_OFS_IRQ_VECTOR)) begin
        irq_vector_r[7:2] <= bus.reg_wdata[7:2];
      end
      irq_vector_r[0] <= 1'b0;
      if (irq_control_r[ADQ_LIM_FLAG_BIT] && irq_control_r[ADQ_LIM_EN_BIT]) begin
        irq_vector_r[ADQ_VEC_WSEL_BIT] <= 1'b0;
      end else if (irq_control_r[ADQ_EOC_FLAG_BIT] && irq_control_r[ADQ_EOC_EN_BIT]) begin
        irq_vector_r[ADQ_VEC_WSEL_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (irq_control_r[ADQ_EOC_FLAG_BIT] && irq_control_r[ADQ_EOC_EN_BIT]) ||
               (irq_control_r[ADQ_LIM_FLAG_BIT] && irq_control_r[ADQ_LIM_EN_BIT]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      case (bus.reg_addr)
        ADQ_OFS_CONTROL: rdata_r <= control_r;
        ADQ_OFS_IRQ_CONTROL: rdata_r <= irq_control_r;
        ADQ_OFS_IRQ_VECTOR: rdata_r <= irq_vector_r;
        ADQ_OFS_LIMIT_RESULT: rdata_r <= limit_result_reg_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign bus.reg_rdata = rdata_r;
  assign bus.conv_strobe = strobe_r;
  assign bus.conv_channel = channel_r;
  assign bus.analog_bias_on = control_r[ADQ_POWER_BIT];
  assign bus.irq_req = irq_r;
  assign bus.irq_priority_level = irq_control_r[ADQ_PRIO_HI:0];
  assign bus.irq_vector = irq_vector_r;
endmodule

//--- verilog/adq_if.sv
/*
  interface: register port, trigger sources, conversion data and interrupt
  lines between the converter control and the core side.
  assumes: one clock, all signals synchronous to it.
*/
`timescale 1ns/1ps
interface adq_if (input wire logic mclk);
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic [7:0] reg_rdata;
  logic trigger_pin;
  logic trigger_pin_alt;
  logic timer_event;
  logic [7:0] conv_data;
  logic conv_strobe;
  logic [2:0] conv_channel;
  logic analog_bias_on;
  logic irq_req;
  logic irq_ack;
  logic [2:0] irq_priority_level;
  logic [7:0] irq_vector;
  modport dev (
    input reg_addr, reg_wdata, reg_wr, trigger_pin, trigger_pin_alt, timer_event,
    input conv_data, irq_ack,
    output reg_rdata, conv_strobe, conv_channel, analog_bias_on, irq_req,
    output irq_priority_level, irq_vector
  );
  modport core (
    output reg_addr, reg_wdata, reg_wr, trigger_pin, trigger_pin_alt, timer_event,
    output conv_data, irq_ack,
    input reg_rdata, conv_strobe, conv_channel, analog_bias_on, irq_req,
    input irq_priority_level, irq_vector
  );
endinterface

//--- verilog/adq_pkg.sv
/*
  package: register map, field positions, reset values and timing of the
  converter sequencer and interrupt control.
  assumes: a single core clock of 100 MHz shared by both ends.
*/
package adq_pkg;
  localparam logic [7:0] ADQ_OFS_CONTROL = 8'hFD;
  localparam logic [7:0] ADQ_OFS_IRQ_CONTROL = 8'hFE;
  localparam logic [7:0] ADQ_OFS_IRQ_VECTOR = 8'hFF;
  localparam logic [7:0] ADQ_OFS_LIMIT_RESULT = 8'hFC;
  localparam logic [7:0] ADQ_RST_CONTROL = 8'h00;
  localparam logic [7:0] ADQ_RST_IRQ_CONTROL = 8'h0F;
  localparam logic [7:0] ADQ_RST_IRQ_VECTOR = 8'h02;
  localparam logic [7:0] ADQ_RST_LIMIT_RESULT = 8'h0F;
  localparam int ADQ_FIRST_HI = 7;
  localparam int ADQ_FIRST_LO = 5;
  localparam int ADQ_PIN_TRIG_BIT = 4;
  localparam int ADQ_TIMER_TRIG_BIT = 3;
  localparam int ADQ_POWER_BIT = 2;
  localparam int ADQ_REPEAT_BIT = 1;
  localparam int ADQ_RUN_BIT = 0;
  localparam int ADQ_EOC_FLAG_BIT = 7;
  localparam int ADQ_LIM_FLAG_BIT = 6;
  localparam int ADQ_EOC_EN_BIT = 5;
  localparam int ADQ_LIM_EN_BIT = 4;
  localparam int ADQ_PRIO_HI = 2;
  localparam int ADQ_VEC_WSEL_BIT = 1;
  localparam logic [2:0] ADQ_LAST_CHANNEL = 3'h7;
  localparam logic [2:0] ADQ_WATCH_CH_A = 3'h6;
  // cycles one channel conversion takes (converter model time)
  localparam logic [7:0] ADQ_CONV_CYCLES = 8'h10;
  localparam int ADQ_BIAS_TIME_US = 60;
  localparam int ADQ_CLK_MHZ = 100;
  localparam int ADQ_BIAS_CYCLES = ADQ_BIAS_TIME_US * ADQ_CLK_MHZ;
  typedef enum logic [2:0] {
    ADQ_IDLE = 3'b001,
    ADQ_CONV = 3'b010,
    ADQ_NEXT = 3'b100
  } adq_state_type;
endpackage
